// ==== core/cmb_pkg.sv ====
package cmb_pkg;
	// Byte addresses of the register words
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TX_FLAG = 8'h04;
	localparam logic [7:0] OFS_IRQ_EN = 8'h08;
	localparam logic [7:0] OFS_ABORT_REQ = 8'h0C;
	localparam logic [7:0] OFS_ABORT_ACK = 8'h10;
	localparam logic [7:0] OFS_TX_SEL = 8'h14;
	localparam logic [7:0] OFS_RX_FLAG = 8'h18;
	localparam logic [7:0] OFS_TIMER = 8'h1C;
	// Windows: addr[7:6] picks the window, addr[5:2] the byte
	localparam logic [1:0] WIN_TX = 2'h1;
	localparam logic [1:0] WIN_RX = 2'h2;
	// Byte positions inside a buffer
	localparam logic [3:0] BYTE_LOCAL_PRIORITY_FIELD = 4'hD;
	localparam logic [3:0] TX_STAMP_HI = 4'hE;
	localparam logic [3:0] TX_STAMP_LO = 4'hF;
	localparam logic [3:0] RX_STAMP_HI = 4'hD;
	localparam logic [3:0] RX_STAMP_LO = 4'hE;
	localparam int TX_BUFS = 3;
	localparam int RX_STAGES = 5;
	localparam logic [2:0] RX_LAST = 3'h4;
	localparam logic [2:0] RX_FULL = 3'h5;
	// Values after reset
	localparam logic [2:0] RST_TXE = 3'h7;
	localparam logic [2:0] RST_SEL = 3'h0;
	localparam logic [15:0] RST_TIMER = 16'h0000;

	typedef struct packed {
		logic ovr_ie;
		logic loopback;
		logic time_en;
		logic init_mode;
	} cmb_ctrl_t;

	typedef struct packed {
		logic we;
		logic [3:0] addr;
		logic [7:0] data;
	} cmb_rx_wr_t;
endpackage : cmb_pkg

// ==== core/cmb_buffer_manager.sv ====
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
// What this block does
// - Smallest 8-bit priority value wins transmit arbitration
// - Ready buffers arbitrate just before start-of-frame
// - Equal priority: lower buffer index wins
// - Ack stamps timer into active buffer when enabled
// - Stamp timer free-runs on bit clock, silent wrap
// - Stamp timer held zero in initialization mode
// - Stamp bytes read-only; read after empty, selected
// - Three transmit buffers: 13 bytes, priority, stamp
// - Clear empty flag to send; set after success
// - Empty flag set raises unmasked transmit interrupt
// - Prioritization reruns on every arbitration, retries too
// - Abort unless transmitting: ack, empty, interrupt
// - Five-stage receive FIFO, CPU sees only foreground
// - Receive-full flag marks valid accepted foreground message
// - Accepted message queued, flag set, interrupt raised
// - Rejected or erroneous frames never enter FIFO
// - Own frames dropped unless loopback mode
// - Full FIFO discards message, flags overrun
module cmb_buffer_manager (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic can_bit_tick,
	input wire logic eng_arb_req,
	output logic eng_tx_valid,
	output logic [1:0] eng_tx_idx,
	input wire logic [3:0] eng_tx_addr,
	output logic [7:0] eng_tx_byte,
	input wire logic eng_tx_done,
	input wire logic eng_tx_fail,
	input wire cmb_pkg::cmb_rx_wr_t eng_rx_wr,
	input wire logic eng_rx_end,
	input wire logic eng_rx_accept,
	input wire logic eng_rx_own,
	output logic tx_irq,
	output logic rx_irq,
	output logic err_irq
);
	import cmb_pkg::*;

	cmb_ctrl_t ctrl_q;
	logic [2:0] txe_q;
	logic [2:0] tx_ie_q;
	logic rx_ie_q;
	logic [2:0] abort_req_q;
	logic [2:0] abort_ack_q;
	logic [2:0] sel_q;
	logic [15:0] timer_q;
	logic ovr_q;
	logic [7:0] tx_mem_q [TX_BUFS][16];
	logic [7:0] bg_q [16];
	logic [7:0] fifo_q [RX_STAGES][16];
	logic [2:0] wr_q;
	logic [2:0] rd_q;
	logic [2:0] cnt_q;
	logic busy_q;
	logic [1:0] act_q;
	logic rd_done_q;
	logic [31:0] rdata_q;
	logic [7:0] tx_byte_q;

	logic wr_en;
	logic [3:0] widx;
	logic [1:0] win;
	logic [2:0] sel_d;
	logic [2:0] txe_clr;
	logic [2:0] abort_now;
	logic [2:0] tx_set;
	logic pick_ok;
	logic [1:0] pick_idx;
	logic [7:0] pick_local_priority_field;
	logic [1:0] sel_idx;
	logic rx_take;
	logic rx_push;
	logic rx_pop;

	assign wr_en = avs_write & avs_byteenable[0];
	assign widx = avs_address[5:2];
	assign win = avs_address[7:6];
	assign rx_pop = wr_en && avs_address == OFS_RX_FLAG && avs_writedata[0]
		&& cnt_q != 3'h0;
	assign txe_clr = (wr_en && avs_address == OFS_TX_FLAG) ? avs_writedata[2:0] : 3'h0;

	// Reads answer on the second cycle so read data comes from flops
	assign avs_waitrequest = avs_read & ~rd_done_q;
	assign avs_readdata = rdata_q;
	assign eng_tx_byte = tx_byte_q;
	assign eng_tx_valid = busy_q;
	assign eng_tx_idx = act_q;
	assign tx_irq = |(txe_q & tx_ie_q);
	assign rx_irq = (cnt_q != 3'h0) & rx_ie_q;
	assign err_irq = ovr_q & ctrl_q.ovr_ie;

	always_comb begin
		sel_idx = 2'h0;
		if (sel_q[1]) begin
			sel_idx = 2'h1;
		end else if (sel_q[2]) begin
			sel_idx = 2'h2;
		end
	end

	// Selection lands on the lowest written buffer that is empty
	always_comb begin
		sel_d = 3'h0;
		for (int i = TX_BUFS - 1; i >= 0; i--) begin
			if (avs_writedata[i] && txe_q[i]) begin
				sel_d = 3'h1 << i;
			end
		end
	end

	// Strict less-than keeps the lower index on a tie
	always_comb begin
		pick_ok = 1'b0;
		pick_idx = 2'h0;
		pick_local_priority_field = 8'hFF;
		for (int i = 0; i < TX_BUFS; i++) begin
			if (!txe_q[i] && !abort_req_q[i]
				&& (!pick_ok || tx_mem_q[i][BYTE_LOCAL_PRIORITY_FIELD] < pick_local_priority_field)) begin
				pick_ok = 1'b1;
				pick_idx = 2'(i);
				pick_local_priority_field = tx_mem_q[i][BYTE_LOCAL_PRIORITY_FIELD];
			end
		end
	end

	// A buffer already on the bus cannot be aborted
	always_comb begin
		abort_now = abort_req_q & ~txe_q;
		if (busy_q) begin
			abort_now[act_q] = 1'b0;
		end
		tx_set = abort_now;
		if (eng_tx_done && busy_q) begin
			tx_set[act_q] = 1'b1;
		end
	end

	// Control and masks have no interlock with init mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= '0;
			tx_ie_q <= 3'h0;
			rx_ie_q <= 1'b0;
		end else if (wr_en && avs_address == OFS_CTRL) begin
			ctrl_q <= avs_writedata[3:0];
		end else if (wr_en && avs_address == OFS_IRQ_EN) begin
			tx_ie_q <= avs_writedata[2:0];
			rx_ie_q <= avs_writedata[4];
		end
	end

	// Hardware set wins over a software clear in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txe_q <= RST_TXE;
		end else begin
			txe_q <= (txe_q & ~txe_clr) | tx_set;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			abort_req_q <= 3'h0;
			abort_ack_q <= 3'h0;
		end else begin
			for (int i = 0; i < TX_BUFS; i++) begin
				if (abort_now[i]) begin
					abort_ack_q[i] <= 1'b1;
					abort_req_q[i] <= 1'b0;
				end else if (tx_set[i]) begin
					abort_ack_q[i] <= 1'b0;
					abort_req_q[i] <= 1'b0;
				end else if (wr_en && avs_address == OFS_ABORT_REQ) begin
					abort_req_q[i] <= avs_writedata[i] & ~txe_q[i];
				end
				if (txe_clr[i] && !tx_set[i]) begin
					abort_ack_q[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sel_q <= RST_SEL;
		end else if (wr_en && avs_address == OFS_TX_SEL) begin
			sel_q <= sel_d;
		end
	end

	// Every arbitration request, retries included, picks afresh
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_q <= 1'b0;
			act_q <= 2'h0;
		end else if (eng_arb_req) begin
			busy_q <= pick_ok;
			act_q <= pick_idx;
		end else if (eng_tx_done || eng_tx_fail) begin
			busy_q <= 1'b0;
		end
	end

	// Wrap is silent; software must extend the count itself
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timer_q <= RST_TIMER;
		end else if (ctrl_q.init_mode) begin
			timer_q <= RST_TIMER;
		end else if (can_bit_tick) begin
			timer_q <= timer_q + 16'h0001;
		end
	end

	// Stamp bytes have no bus write path at all
	always_ff @(posedge clk) begin
		for (int i = 0; i < TX_BUFS; i++) begin
			for (int j = 0; j < 16; j++) begin
				if (wr_en && win == WIN_TX && sel_q[i] && txe_q[i] && widx == 4'(j)
					&& 4'(j) < TX_STAMP_HI) begin
					tx_mem_q[i][j] <= avs_writedata[7:0];
				end
			end
		end
		if (eng_tx_done && busy_q && ctrl_q.time_en) begin
			tx_mem_q[act_q][TX_STAMP_HI] <= timer_q[15:8];
			tx_mem_q[act_q][TX_STAMP_LO] <= timer_q[7:0];
		end
	end

	// Fetch answers one cycle late, so the engine leads with the address
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_byte_q <= 8'h00;
		end else begin
			tx_byte_q <= tx_mem_q[act_q][eng_tx_addr];
		end
	end

	// Own frames still land in the background buffer
	always_ff @(posedge clk) begin
		if (eng_rx_wr.we) begin
			bg_q[eng_rx_wr.addr] <= eng_rx_wr.data;
		end
	end

	assign rx_take = eng_rx_end && eng_rx_accept
		&& (!eng_rx_own || ctrl_q.loopback);
	assign rx_push = rx_take && (cnt_q != RX_FULL || rx_pop);

	always_ff @(posedge clk) begin
		if (rx_push) begin
			for (int j = 0; j < 16; j++) begin
				fifo_q[wr_q][j] <= bg_q[j];
			end
			if (ctrl_q.time_en) begin
				fifo_q[wr_q][RX_STAMP_HI] <= timer_q[15:8];
				fifo_q[wr_q][RX_STAMP_LO] <= timer_q[7:0];
			end
		end
	end

	// A count, not a pointer compare, tells five full stages from none
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_q <= 3'h0;
			rd_q <= 3'h0;
			cnt_q <= 3'h0;
		end else begin
			if (rx_push) begin
				wr_q <= (wr_q == RX_LAST) ? 3'h0 : wr_q + 3'h1;
			end
			if (rx_pop) begin
				rd_q <= (rd_q == RX_LAST) ? 3'h0 : rd_q + 3'h1;
			end
			if (rx_push && !rx_pop) begin
				cnt_q <= cnt_q + 3'h1;
			end else if (rx_pop && !rx_push) begin
				cnt_q <= cnt_q - 3'h1;
			end
		end
	end

	// Overrun set wins over a clear in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ovr_q <= 1'b0;
		end else if (rx_take && !rx_push) begin
			ovr_q <= 1'b1;
		end else if (wr_en && avs_address == OFS_RX_FLAG && avs_writedata[1]) begin
			ovr_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_done_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			rd_done_q <= avs_read & ~rd_done_q;
			if (avs_read && !rd_done_q) begin
				rdata_q <= 32'h0000_0000;
				if (win == WIN_TX) begin
					rdata_q[7:0] <= tx_mem_q[sel_idx][widx];
				end else if (win == WIN_RX && widx != 4'hF) begin
					rdata_q[7:0] <= fifo_q[rd_q][widx];
				end else if (avs_address == OFS_CTRL) begin
					rdata_q[3:0] <= ctrl_q;
				end else if (avs_address == OFS_TX_FLAG) begin
					rdata_q[2:0] <= txe_q;
				end else if (avs_address == OFS_IRQ_EN) begin
					rdata_q[4:0] <= {rx_ie_q, 1'b0, tx_ie_q};
				end else if (avs_address == OFS_ABORT_REQ) begin
					rdata_q[2:0] <= abort_req_q;
				end else if (avs_address == OFS_ABORT_ACK) begin
					rdata_q[2:0] <= abort_ack_q;
				end else if (avs_address == OFS_TX_SEL) begin
					rdata_q[2:0] <= sel_q;
				end else if (avs_address == OFS_RX_FLAG) begin
					rdata_q[6:0] <= {cnt_q, 2'h0, ovr_q, cnt_q != 3'h0};
				end else if (avs_address == OFS_TIMER) begin
					rdata_q[15:0] <= timer_q;
				end
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_arb_lowest: assert property (eng_arb_req && pick_ok |=> busy_q
		&& !txe_q[act_q] && !(!txe_q[0] && !abort_req_q[0]
		&& tx_mem_q[0][BYTE_LOCAL_PRIORITY_FIELD] < tx_mem_q[act_q][BYTE_LOCAL_PRIORITY_FIELD])) else $error("arb not lowest");
	a_tie_index: assert property (eng_arb_req && !txe_q[1] && !txe_q[2]
		&& abort_req_q[2:1] == 2'h0 && tx_mem_q[1][BYTE_LOCAL_PRIORITY_FIELD] == tx_mem_q[2][BYTE_LOCAL_PRIORITY_FIELD]
		|=> act_q != 2'h2) else $error("tie not lower index");
	a_done_empty: assert property (eng_tx_done && busy_q
		|=> txe_q[$past(act_q)] && !busy_q)
		else $error("done not empty");
	a_abort_grant: assert property (abort_req_q[2] && !txe_q[2]
		&& !(busy_q && act_q == 2'h2) |=> abort_ack_q[2] && txe_q[2] && (tx_irq || !tx_ie_q[2]))
		else $error("abort not granted");
	a_timer_init: assert property (ctrl_q.init_mode
		|=> timer_q == RST_TIMER)
		else $error("timer not cleared");
	a_timer_count: assert property (!ctrl_q.init_mode && can_bit_tick
		|=> timer_q == $past(timer_q) + 16'h0001)
		else $error("timer not counting");
	a_own_drop: assert property (eng_rx_end && eng_rx_own && !ctrl_q.loopback
		&& !rx_pop |=> $stable(cnt_q))
		else $error("own frame queued");
	a_push_flag: assert property (rx_push
		|=> cnt_q != 3'h0 && rx_irq == rx_ie_q)
		else $error("push without flag");
	a_overrun: assert property (rx_take && cnt_q == RX_FULL && !rx_pop
		|=> ovr_q && cnt_q == RX_FULL)
		else $error("overrun missed");
	a_read_answer: assert property (avs_read && !rd_done_q
		|-> avs_waitrequest ##1 (!avs_waitrequest || !avs_read))
		else $error("read answer late");
	a_pop_count: assert property (rx_pop && !rx_push
		|=> cnt_q == $past(cnt_q) - 3'h1)
		else $error("pop not counted");
endmodule : cmb_buffer_manager

// ==== verification/cmb_engine_model.sv ====
`timescale 1ns/10ps
module cmb_engine_model (
	input wire logic clk,
	output logic can_bit_tick,
	output logic eng_arb_req,
	output logic [3:0] eng_tx_addr,
	output logic eng_tx_done,
	output logic eng_tx_fail,
	output cmb_pkg::cmb_rx_wr_t eng_rx_wr,
	output logic eng_rx_end,
	output logic eng_rx_accept,
	output logic eng_rx_own
);
	import cmb_pkg::*;
	initial begin
		{can_bit_tick, eng_arb_req, eng_tx_done, eng_tx_fail} = 4'h0;
		{eng_rx_end, eng_rx_accept, eng_rx_own} = 3'h0;
		eng_tx_addr = 4'h0;
		eng_rx_wr = '0;
	end
	// Ticks only on demand, so stamp values are known
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			can_bit_tick <= 1'b1;
			@(posedge clk);
			can_bit_tick <= 1'b0;
		end
	endtask : ticks
	task automatic arb();
		@(posedge clk);
		eng_arb_req <= 1'b1;
		@(posedge clk);
		eng_arb_req <= 1'b0;
	endtask : arb
	task automatic fetch(input logic [3:0] a);
		@(posedge clk);
		eng_tx_addr <= a;
	endtask : fetch
	task automatic fin(input logic fail);
		@(posedge clk);
		eng_tx_fail <= fail;
		eng_tx_done <= ~fail;
		@(posedge clk);
		eng_tx_fail <= 1'b0;
		eng_tx_done <= 1'b0;
	endtask : fin
	// Released data line shows junk, not the old byte
	task automatic frame(input logic [7:0] b0, input logic ok, input logic acc, input logic own);
		@(posedge clk);
		eng_rx_wr <= '{1'b1, 4'h0, b0};
		@(posedge clk);
		eng_rx_wr <= '{1'b0, 4'h0, ~b0};
		eng_rx_end <= ok;
		eng_rx_accept <= acc;
		eng_rx_own <= own;
		@(posedge clk);
		eng_rx_end <= 1'b0;
	endtask : frame
endmodule : cmb_engine_model

// ==== verification/cmb_buffer_manager_test.sv ====
`timescale 1ns/10ps
module cmb_buffer_manager_test;
	import cmb_pkg::*;
	logic clk, rst, avs_read, avs_write, avs_waitrequest;
	logic [7:0] avs_address;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rd_q;
	logic can_bit_tick, eng_arb_req, eng_tx_valid, eng_tx_done, eng_tx_fail;
	logic eng_rx_end, eng_rx_accept, eng_rx_own, tx_irq, rx_irq, err_irq;
	logic [1:0] eng_tx_idx;
	logic [3:0] eng_tx_addr;
	logic [7:0] eng_tx_byte;
	cmb_rx_wr_t eng_rx_wr;
	int err_count, cmp_count, cyc;
	logic [3:0] wr_be = 4'h1;
	logic [7:0] local_priority_field [3] = '{8'h05, 8'h03, 8'h03};
	cmb_buffer_manager u_dut (.clk, .rst, .avs_address, .avs_read, .avs_write,
		.avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .can_bit_tick,
		.eng_arb_req, .eng_tx_valid, .eng_tx_idx, .eng_tx_addr, .eng_tx_byte, .eng_tx_done,
		.eng_tx_fail, .eng_rx_wr, .eng_rx_end, .eng_rx_accept, .eng_rx_own, .tx_irq,
		.rx_irq, .err_irq);
	cmb_engine_model u_eng (.clk, .can_bit_tick, .eng_arb_req, .eng_tx_addr, .eng_tx_done,
		.eng_tx_fail, .eng_rx_wr, .eng_rx_end, .eng_rx_accept, .eng_rx_own);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	function automatic logic [7:0] win(input logic [1:0] w, input logic [3:0] j);
		return {w, j, 2'b00};
	endfunction : win
	task automatic close_out();
		$display("errors %0d, comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chkb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= wr_be;
		avs_write <= 1'b1;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		avs_write <= 1'b0;
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		avs_address <= a;
		avs_read <= 1'b1;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		rd_q = avs_readdata;
		avs_read <= 1'b0;
		chk(rd_q, exp);
	endtask : rchk
	// Byte 0 of buffer i was loaded with A0 plus i
	task automatic ex_tx(input logic v, input logic [1:0] i);
		repeat (3) @(negedge clk);
		chkb(eng_tx_valid, v);
		if (v) chk({22'h0, eng_tx_idx, eng_tx_byte}, {22'h0, i, 8'hA0 + 8'(i)});
	endtask : ex_tx
	// Hang guard, far above the sequence length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			close_out();
		end
	end
	initial begin
		rst = 1'b1;
		{avs_read, avs_write, avs_address} = 10'h000;
		avs_byteenable = 4'h1;
		avs_writedata = 32'h0000_0000;
		{err_count, cmp_count, cyc} = {32'h0, 32'h0, 32'h0};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rchk(OFS_TX_FLAG, 32'h0000_0007);
		u_eng.ticks(3);
		wr(OFS_CTRL, 32'h0000_0001);
		u_eng.ticks(2);
		rchk(OFS_TIMER, 32'h0000_0000);
		wr(OFS_CTRL, 32'h0000_000A);
		wr(OFS_IRQ_EN, 32'h0000_0017);
		wr_be = 4'hE;
		wr(OFS_IRQ_EN, 32'h0000_0000);
		wr_be = 4'h1;
		rchk(OFS_IRQ_EN, 32'h0000_0017);
		for (int i = 0; i < 3; i++) begin
			wr(OFS_TX_SEL, 32'(1 << i));
			rchk(OFS_TX_SEL, 32'(1 << i));
			wr(win(WIN_TX, 4'h0), 32'h0000_00A0 + 32'(i));
			wr(win(WIN_TX, BYTE_LOCAL_PRIORITY_FIELD), {24'h0, local_priority_field[i]});
			wr(win(WIN_TX, TX_STAMP_HI), 32'h0000_00FF);
			rchk(win(WIN_TX, BYTE_LOCAL_PRIORITY_FIELD), {24'h0, local_priority_field[i]});
		end
		chkb(tx_irq, 1'b1);
		wr(OFS_TX_FLAG, 32'h0000_0007);
		wr(win(WIN_TX, BYTE_LOCAL_PRIORITY_FIELD), 32'h0000_0000);
		rchk(OFS_TX_FLAG, 32'h0000_0000);
		chkb(tx_irq, 1'b0);
		u_eng.ticks(4);
		u_eng.arb();
		ex_tx(1'b1, 2'd1);
		u_eng.fetch(BYTE_LOCAL_PRIORITY_FIELD);
		repeat (2) @(negedge clk);
		chk({24'h0, eng_tx_byte}, {24'h0, local_priority_field[1]});
		u_eng.fetch(4'h0);
		u_eng.fin(1'b1);
		u_eng.arb();
		ex_tx(1'b1, 2'd1);
		u_eng.ticks(4);
		u_eng.fin(1'b0);
		rchk(OFS_TX_FLAG, 32'h0000_0002);
		chkb(tx_irq, 1'b1);
		wr(OFS_TX_SEL, 32'h0000_0002);
		rchk(win(WIN_TX, TX_STAMP_HI), 32'h0000_0000);
		rchk(win(WIN_TX, TX_STAMP_LO), 32'h0000_0008);
		u_eng.arb();
		ex_tx(1'b1, 2'd2);
		wr(OFS_ABORT_REQ, 32'h0000_0005);
		rchk(OFS_ABORT_ACK, 32'h0000_0001);
		rchk(OFS_TX_FLAG, 32'h0000_0003);
		u_eng.fin(1'b0);
		rchk(OFS_TX_FLAG, 32'h0000_0007);
		rchk(OFS_ABORT_ACK, 32'h0000_0001);
		u_eng.arb();
		ex_tx(1'b0, 2'd0);
		wr(OFS_TX_FLAG, 32'h0000_0004);
		wr(OFS_ABORT_REQ, 32'h0000_0004);
		rchk(OFS_ABORT_ACK, 32'h0000_0005);
		rchk(OFS_TX_FLAG, 32'h0000_0007);
		chkb(tx_irq, 1'b1);
		wr(OFS_TIMER, 32'h0000_1234);
		rchk(OFS_TIMER, 32'h0000_0008);
		rchk(8'hFC, 32'h0000_0000);
		u_eng.ticks(3);
		u_eng.frame(8'h77, 1'b1, 1'b0, 1'b0);
		u_eng.frame(8'h55, 1'b0, 1'b1, 1'b0);
		u_eng.frame(8'h66, 1'b1, 1'b1, 1'b1);
		for (int i = 1; i < 7; i++) u_eng.frame(8'(i), 1'b1, 1'b1, 1'b0);
		rchk(OFS_RX_FLAG, 32'h0000_0053);
		chkb(rx_irq, 1'b1);
		chkb(err_irq, 1'b1);
		for (int i = 1; i < 6; i++) begin
			rchk(win(WIN_RX, 4'h0), 32'(i));
			rchk(win(WIN_RX, RX_STAMP_LO), 32'h0000_000B);
			wr(OFS_RX_FLAG, 32'h0000_0001);
		end
		rchk(OFS_RX_FLAG, 32'h0000_0002);
		chkb(rx_irq, 1'b0);
		wr(OFS_RX_FLAG, 32'h0000_0002);
		wr(OFS_CTRL, 32'h0000_000E);
		u_eng.frame(8'h66, 1'b1, 1'b1, 1'b1);
		rchk(OFS_RX_FLAG, 32'h0000_0011);
		rchk(win(WIN_RX, 4'h0), 32'h0000_0066);
		close_out();
	end
endmodule : cmb_buffer_manager_test
